// ==== sso_pkg.sv ====
package sso_pkg;

    // Clock rate and derived counts
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned PWRUP_MIN_MS = 2500;
    localparam int unsigned PWRUP_MAX_MS = 3500;
    localparam int unsigned PWRUP_MID_MS = 3000;
    localparam int unsigned PWRUP_CYC = PWRUP_MID_MS * (CLK_HZ / 1000);
    localparam int unsigned MS_CYC = CLK_HZ / 1000;

    // Speed figures in r/min
    localparam int SPD_W = 16;
    localparam logic signed [15:0] ATT_MARGIN = 16'sh0014;
    localparam logic signed [15:0] ATT_LOW_PRESET = 16'sh0014;
    localparam logic signed [15:0] NZ_HYST = 16'sh0014;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_SETTLE = 8'h04;
    localparam logic [7:0] OFF_ZSPD = 8'h08;
    localparam logic [7:0] OFF_BRKDLY = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_EVT = 8'h14;
    localparam logic [7:0] OFF_EVTCLR = 8'h18;
    localparam logic [7:0] OFF_EVTEN = 8'h1C;

    // Reset values
    localparam logic [15:0] SETTLE_RST = 16'h0064;
    localparam logic [15:0] ZSPD_RST = 16'h0032;
    localparam logic [15:0] BRKDLY_RST = 16'h0000;
    localparam logic [1:0] CTRL_RST = 2'h0;

    // Control modes
    typedef enum logic [1:0] {
        SSO_MODE_POS = 2'b00,
        SSO_MODE_SPD = 2'b01,
        SSO_MODE_TRQ = 2'b10
    } sso_mode_t;

    // Event bit positions
    localparam int EV_BRK_OFF = 0;
    localparam int EV_FAULT = 1;
    localparam int EV_READY = 2;
    localparam int EV_NZ = 3;
    localparam int EV_W = 4;

    // Status outputs travelling together
    typedef struct packed {
        logic brake_release_out;
        logic fault_n_out;
        logic position_settled;
        logic drive_ready;
        logic speed_attained;
        logic speed_limit_active;
        logic near_zero_speed;
    } sso_flags_t;

endpackage : sso_pkg

// ==== sso_status_outputs.sv ====
module sso_status_outputs
    import sso_pkg::*;
#(
    parameter int unsigned PWRUP_CYCLES = PWRUP_CYC, // Power-up fault hold
    parameter int unsigned MS_CYCLES = MS_CYC // Cycles per millisecond tick
) (
    input wire logic hclk, // System clock
    input wire logic hresetn, // Async reset, active low
    input wire logic hsel, // AHB select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB ready in
    output logic [31:0] hrdata, // AHB read data
    output logic hreadyout, // AHB ready out
    output logic hresp, // AHB response
    input wire logic servo_on, // Servo-on state
    input wire logic alarm, // Alarm present
    input wire logic base_shutoff, // Protective base shut-off
    input wire logic drive_ok, // Drive ready to operate
    input wire logic [1:0] ctrl_mode, // Control mode
    input wire logic signed [31:0] droop_pulses, // Droop pulse count
    input wire logic signed [15:0] motor_speed, // Motor speed r/min
    input wire logic signed [15:0] preset_speed, // Preset speed r/min
    input wire logic signed [15:0] speed_limit, // Speed limit r/min
    output sso_flags_t flags, // Status outputs
    output logic irq // Interrupt level
);

    initial begin
        if (PWRUP_CYCLES < 2 || MS_CYCLES < 1) begin
            $error("sso_status_outputs: bad count parameter");
        end
    end

    // Registers and state
    logic [15:0] settle_window_param_q;
    logic [15:0] zero_speed_threshold_param_q;
    logic [15:0] brake_delay_param_q;
    logic [EV_W-1:0] evt_q, evt_en_q;
    logic [31:0] pwr_cnt_q;
    logic pwr_done_q;
    logic [31:0] ms_cnt_q;
    logic [15:0] brk_cnt_q;
    logic nz_q;
    sso_flags_t flags_q, flags_d;
    logic [7:0] addr_q;
    logic wr_q, rd_pend_q;

    // Address phase decode
    wire logic acc = hsel & hready & htrans[1];
    wire logic wr_now = wr_q;
    wire logic [31:0] wdat = hwdata;

    // Bus slave: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_q <= 8'h00;
            wr_q <= 1'b0;
            rd_pend_q <= 1'b0;
        end else begin
            addr_q <= haddr[7:0];
            wr_q <= acc & hwrite;
            rd_pend_q <= acc & ~hwrite;
        end
    end

    // Write decode
    wire logic wr_settle = wr_now && addr_q == OFF_SETTLE;
    wire logic wr_zspd = wr_now && addr_q == OFF_ZSPD;
    wire logic wr_brk = wr_now && addr_q == OFF_BRKDLY;
    wire logic wr_clr = wr_now && addr_q == OFF_EVTCLR;
    wire logic wr_en = wr_now && addr_q == OFF_EVTEN;

    // Parameter registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            settle_window_param_q <= SETTLE_RST;
            zero_speed_threshold_param_q <= ZSPD_RST;
            brake_delay_param_q <= BRKDLY_RST;
            evt_en_q <= '0;
        end else begin
            if (wr_settle) settle_window_param_q <= wdat[15:0];
            if (wr_zspd) zero_speed_threshold_param_q <= wdat[15:0];
            if (wr_brk) brake_delay_param_q <= wdat[15:0];
            if (wr_en) evt_en_q <= wdat[EV_W-1:0];
        end
    end

    // Read mux, data held in a flop for the data phase
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (haddr[7:0])
            OFF_SETTLE: rd_mux = {16'h0000, settle_window_param_q};
            OFF_ZSPD: rd_mux = {16'h0000, zero_speed_threshold_param_q};
            OFF_BRKDLY: rd_mux = {16'h0000, brake_delay_param_q};
            OFF_STATUS: rd_mux = {25'h0, flags_q};
            OFF_EVT: rd_mux = {28'h0, evt_q};
            OFF_EVTEN: rd_mux = {28'h0, evt_en_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) hrdata <= 32'h0000_0000;
        else if (acc && !hwrite) hrdata <= rd_mux;
    end

    // Power-on timer for fault output
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwr_cnt_q <= 32'h0000_0000;
            pwr_done_q <= 1'b0;
        end else if (!pwr_done_q) begin
            pwr_cnt_q <= pwr_cnt_q + 32'h0000_0001;
            pwr_done_q <= (pwr_cnt_q == PWRUP_CYCLES - 2);
        end
    end

    // Millisecond tick for brake delay
    wire logic ms_tick = (ms_cnt_q == MS_CYCLES - 1);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) ms_cnt_q <= 32'h0000_0000;
        else ms_cnt_q <= ms_tick ? 32'h0000_0000 : ms_cnt_q + 32'h0000_0001;
    end

    // Brake release: immediate drop, release after delay in ms
    wire logic run_ok = servo_on & ~alarm;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) brk_cnt_q <= 16'h0000;
        else if (!run_ok) brk_cnt_q <= 16'h0000;
        else if (ms_tick && brk_cnt_q < brake_delay_param_q) brk_cnt_q <= brk_cnt_q + 16'h0001;
    end
    wire logic brk_rel = run_ok && brk_cnt_q >= brake_delay_param_q;

    // Settle window compare on droop magnitude
    wire logic signed [31:0] droop_abs = droop_pulses < 0 ? -droop_pulses : droop_pulses;
    wire logic in_win = droop_abs <= $signed({16'h0000, settle_window_param_q});
    wire logic settled = in_win && ctrl_mode == SSO_MODE_POS;

    // Speed attained band
    wire logic signed [17:0] pre = 18'(preset_speed);
    wire logic signed [17:0] pre_abs = pre < 0 ? -pre : pre;
    wire logic signed [17:0] band = 18'((pre_abs / 20) + 18'(ATT_MARGIN));
    wire logic signed [17:0] err = 18'(motor_speed) - pre;
    wire logic in_band = err <= band && err >= -band;
    wire logic low_pre = pre_abs <= 18'(ATT_LOW_PRESET);
    wire logic att_hit = servo_on && ctrl_mode == SSO_MODE_SPD && (in_band || low_pre);

    // Speed limit compare in torque mode
    wire logic signed [17:0] spd_abs =
        motor_speed < 0 ? -18'(motor_speed) : 18'(motor_speed);
    wire logic signed [17:0] lim_abs =
        speed_limit < 0 ? -18'(speed_limit) : 18'(speed_limit);
    wire logic lim_hit = servo_on && ctrl_mode == SSO_MODE_TRQ && spd_abs >= lim_abs;

    // Near-zero hysteresis thresholds
    wire logic signed [17:0] zon = 18'({2'b00, zero_speed_threshold_param_q});
    wire logic signed [17:0] zoff = zon + 18'(NZ_HYST);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) nz_q <= 1'b1;
        else if (spd_abs <= zon) nz_q <= 1'b1;
        else if (spd_abs >= zoff) nz_q <= 1'b0;
    end

    // Output assembly
    always_comb begin
        flags_d.brake_release_out = brk_rel;
        flags_d.fault_n_out = pwr_done_q & ~base_shutoff & ~alarm;
        flags_d.position_settled = settled;
        flags_d.drive_ready = servo_on & drive_ok & ~alarm;
        flags_d.speed_attained = att_hit;
        flags_d.speed_limit_active = lim_hit;
        flags_d.near_zero_speed = nz_q;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) flags_q <= '0;
        else flags_q <= flags_d;
    end
    assign flags = flags_q;

    // Sticky events: set wins over clear
    wire logic [EV_W-1:0] evt_set = {
        flags_d.near_zero_speed & ~flags_q.near_zero_speed,
        flags_d.drive_ready & ~flags_q.drive_ready,
        ~flags_d.fault_n_out & flags_q.fault_n_out,
        ~flags_d.brake_release_out & flags_q.brake_release_out
    };
    wire logic [EV_W-1:0] evt_clr = wr_clr ? wdat[EV_W-1:0] : '0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) evt_q <= '0;
        else evt_q <= (evt_q & ~evt_clr) | evt_set;
    end
    assign irq = |(evt_q & evt_en_q);

    // Checks
    brake_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !run_ok |=> !flags.brake_release_out) else $error("brake on while stopped");
    fault_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
        base_shutoff |=> !flags.fault_n_out) else $error("fault high at shutoff");
    fault_early_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !pwr_done_q |=> !flags.fault_n_out) else $error("fault early");
    settle_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl_mode != SSO_MODE_POS |=> !flags.position_settled) else $error("settled wrong mode");
    att_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !servo_on |=> !flags.speed_attained) else $error("attained at servo off");
    att_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
        servo_on && ctrl_mode == SSO_MODE_SPD && low_pre |=> flags.speed_attained)
        else $error("attained low preset");
    lim_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_mode != SSO_MODE_TRQ || !servo_on) |=> !flags.speed_limit_active)
        else $error("limit wrong mode");
    nz_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
        spd_abs <= zon |=> ##1 flags.near_zero_speed) else $error("near zero missed");
    nz_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        nz_q && spd_abs < zoff |=> nz_q) else $error("near zero dropped early");

    // Slave never stalls and never errors
    bus_okay_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout && !hresp) else $error("bus stalled or errored");

    // Write request captured for data phase
    wr_capture_a: assert property (@(posedge hclk) disable iff (!hresetn)
        acc && hwrite |=> wr_q) else $error("write not captured");

    // Read data loaded at address phase
    rd_capture_a: assert property (@(posedge hclk) disable iff (!hresetn)
        acc && !hwrite |=> hrdata == $past(rd_mux)) else $error("read data wrong");

    // Read data holds between reads
    rd_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !(acc && !hwrite) |=> $stable(hrdata)) else $error("read data moved");

    // Settle window takes written value
    settle_wr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_settle |=> settle_window_param_q == $past(wdat[15:0])) else $error("window write");

    // Settle window kept without write
    settle_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !wr_settle |=> $stable(settle_window_param_q)) else $error("window moved");

    // Threshold takes written value
    thr_wr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_zspd |=> zero_speed_threshold_param_q == $past(wdat[15:0]))
        else $error("threshold write");

    // Brake delay takes written value
    dly_wr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_brk |=> brake_delay_param_q == $past(wdat[15:0])) else $error("delay write");

    // Event enable takes written value
    en_wr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_en |=> evt_en_q == $past(wdat[EV_W-1:0])) else $error("enable write");

    // Power-on counter advances until done
    pwr_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !pwr_done_q |=> pwr_cnt_q == $past(pwr_cnt_q) + 32'h0000_0001)
        else $error("power count stalled");

    // Power-on done is sticky
    pwr_stay_a: assert property (@(posedge hclk) disable iff (!hresetn)
        pwr_done_q |=> pwr_done_q) else $error("power done dropped");

    // Power-on done no later than the count
    pwr_late_a: assert property (@(posedge hclk) disable iff (!hresetn)
        pwr_cnt_q >= PWRUP_CYCLES - 1 |-> pwr_done_q) else $error("power done late");

    // Healthy only after power-on delay
    fault_rise_a: assert property (@(posedge hclk) disable iff (!hresetn)
        flags.fault_n_out |-> pwr_done_q) else $error("healthy before delay");

    // Healthy rises when nothing blocks it
    fault_up_a: assert property (@(posedge hclk) disable iff (!hresetn)
        pwr_done_q && !base_shutoff && !alarm |=> flags.fault_n_out)
        else $error("healthy missing");

    // Alarm drops the healthy output
    fault_alarm_a: assert property (@(posedge hclk) disable iff (!hresetn)
        alarm |=> !flags.fault_n_out) else $error("healthy during alarm");

    // Millisecond counter stays in range
    ms_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ms_cnt_q < MS_CYCLES) else $error("tick counter out of range");

    // Brake delay count cleared when stopped
    brk_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !run_ok |=> brk_cnt_q == 16'h0000) else $error("brake count kept");

    // Brake held while delay runs
    brk_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
        run_ok && brk_cnt_q < brake_delay_param_q |=> !flags.brake_release_out)
        else $error("brake released early");

    // Brake delay counts only on ticks
    brk_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
        run_ok && !ms_tick |=> brk_cnt_q == $past(brk_cnt_q)) else $error("brake count step");

    // Brake released once delay met
    brk_rel_a: assert property (@(posedge hclk) disable iff (!hresetn)
        run_ok && brk_cnt_q >= brake_delay_param_q |=> flags.brake_release_out)
        else $error("brake not released");

    // Brake drops on alarm
    brk_alarm_a: assert property (@(posedge hclk) disable iff (!hresetn)
        alarm |=> !flags.brake_release_out) else $error("brake on in alarm");

    // Settled inside window in position mode
    settle_in_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl_mode == SSO_MODE_POS && in_win |=> flags.position_settled)
        else $error("settled missing");

    // Not settled outside window
    settle_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !in_win |=> !flags.position_settled) else $error("settled outside window");

    // Ready when servo on and drive fit
    ready_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
        servo_on && drive_ok && !alarm |=> flags.drive_ready) else $error("ready missing");

    // Not ready at servo off
    ready_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !servo_on |=> !flags.drive_ready) else $error("ready at servo off");

    // Attained inside the band
    att_band_a: assert property (@(posedge hclk) disable iff (!hresetn)
        servo_on && ctrl_mode == SSO_MODE_SPD && in_band |=> flags.speed_attained)
        else $error("attained missing");

    // Not attained outside the band
    att_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !in_band && !low_pre |=> !flags.speed_attained) else $error("attained outside");

    // Attained only in speed mode
    att_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl_mode != SSO_MODE_SPD |=> !flags.speed_attained) else $error("attained mode");

    // Limit active at or above limit
    lim_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
        servo_on && ctrl_mode == SSO_MODE_TRQ && spd_abs >= lim_abs
        |=> flags.speed_limit_active) else $error("limit missing");

    // Limit inactive below limit
    lim_below_a: assert property (@(posedge hclk) disable iff (!hresetn)
        spd_abs < lim_abs |=> !flags.speed_limit_active) else $error("limit below");

    // Limit inactive at servo off
    lim_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !servo_on |=> !flags.speed_limit_active) else $error("limit at servo off");

    // Near-zero set at threshold
    nz_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        spd_abs <= zon |=> nz_q) else $error("near zero not set");

    // Near-zero cleared at upper level
    nz_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        spd_abs >= zoff |=> !nz_q) else $error("near zero not cleared");

    // Near-zero stays off inside hysteresis
    nz_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !nz_q && spd_abs > zon |=> !nz_q) else $error("near zero set early");

    // Event set wins over clear
    evt_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        |evt_set |=> (evt_q & $past(evt_set)) == $past(evt_set)) else $error("event lost");

    // Event clear removes bits
    evt_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_clr && evt_set == '0 |=> (evt_q & $past(evt_clr)) == '0) else $error("event kept");

    // No interrupt while all masked
    irq_mask_a: assert property (@(posedge hclk) disable iff (!hresetn)
        evt_en_q == '0 |-> !irq) else $error("interrupt while masked");

endmodule : sso_status_outputs

// ==== sso_ctrl_model.sv ====
// Controller side: times the healthy flag after reset
module sso_ctrl_model
    import sso_pkg::*;
(
    input wire logic hclk, // Clock
    input wire logic hresetn, // Reset, active low
    input wire sso_flags_t flags, // Observed outputs
    output int rise_cyc // Cycles to healthy
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    logic seen;
    // Latch first rise of the healthy output
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 0;
            seen <= 1'b0;
            rise_cyc <= 0;
        end else begin
            cnt <= cnt + 1;
            if (flags.fault_n_out && !seen) begin
                seen <= 1'b1;
                rise_cyc <= cnt;
            end
        end
    end
endmodule : sso_ctrl_model

// ==== sso_status_outputs_tb.sv ====
module sso_status_outputs_tb;
    import sso_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PW = 200;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic servo_on = 1'b0;
    logic alarm = 1'b0;
    logic base_shutoff = 1'b0;
    logic drive_ok = 1'b0;
    logic [1:0] ctrl_mode = 2'h0;
    logic signed [31:0] droop_pulses = 32'sh0;
    logic signed [15:0] motor_speed = 16'sh0;
    logic signed [15:0] preset_speed = 16'sh0;
    logic signed [15:0] speed_limit = 16'sh0;
    sso_flags_t flags;
    logic irq;
    int rise_cyc;
    int fail_count = 0;
    int compares = 0;
    int cyc = 0;
    int nz_v[7] = '{50, 69, 70, 51, 50, -69, -70};
    logic nz_e[7] = '{1, 1, 0, 0, 1, 1, 0};
    logic [31:0] d;

    sso_status_outputs #(.PWRUP_CYCLES(PW), .MS_CYCLES(4)) i_sso_status_outputs (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .servo_on(servo_on), .alarm(alarm),
        .base_shutoff(base_shutoff), .drive_ok(drive_ok), .ctrl_mode(ctrl_mode),
        .droop_pulses(droop_pulses), .motor_speed(motor_speed),
        .preset_speed(preset_speed), .speed_limit(speed_limit), .flags(flags), .irq(irq));
    sso_ctrl_model i_sso_ctrl_model (.hclk(hclk), .hresetn(hresetn), .flags(flags),
        .rise_cyc(rise_cyc));

    // Clock and hang guard
    always #12.5 hclk = ~hclk;
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask : tick

    // One single-word transfer, address phase then data phase
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        d = hrdata;
    endtask : bus

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, d, e);
        chk("rsp", 32'(hresp), 32'h0);
    endtask : rdc

    task automatic run(input logic [1:0] m, input logic s, input int p, input int v);
        ctrl_mode <= m;
        servo_on <= s;
        preset_speed <= 16'(p);
        motor_speed <= 16'(v);
        speed_limit <= 16'sh012C;
        tick(4);
    endtask : run

    // Main sequence
    initial begin
        tick(20);
        chk("rst", 32'(flags), 32'h0);
        hresetn <= 1'b1;
        tick(1);
        rdc("win", OFF_SETTLE, 32'h64);
        rdc("thr", OFF_ZSPD, 32'h32);
        rdc("dly", OFF_BRKDLY, 32'h0);
        rdc("unm", 8'h40, 32'h0);
        tick(PW + 40);
        chk("pwr", 32'(rise_cyc >= PW * 5 / 6 && rise_cyc <= PW * 7 / 6), 32'h1);
        bus(1'b1, OFF_EVTEN, 32'h1);
        servo_on <= 1'b1;
        drive_ok <= 1'b1;
        tick(16);
        chk("brk", 32'(flags.brake_release_out), 32'h1);
        chk("rdy", 32'(flags.drive_ready), 32'h1);
        alarm <= 1'b1;
        tick(3);
        chk("brk", 32'(flags.brake_release_out), 32'h0);
        chk("irq", 32'(irq), 32'h1);
        bus(1'b1, OFF_EVTEN, 32'h0);
        tick(1);
        chk("msk", 32'(irq), 32'h0);
        bus(1'b1, OFF_EVTEN, 32'h1);
        bus(1'b1, OFF_EVTCLR, 32'hF);
        rdc("evt", OFF_EVT, 32'h0);
        chk("clr", 32'(irq), 32'h0);
        alarm <= 1'b0;
        servo_on <= 1'b0;
        base_shutoff <= 1'b1;
        tick(3);
        chk("flt", 32'(flags.fault_n_out), 32'h0);
        base_shutoff <= 1'b0;
        bus(1'b1, OFF_BRKDLY, 32'h2);
        servo_on <= 1'b1;
        tick(4);
        chk("dl0", 32'(flags.brake_release_out), 32'h0);
        tick(12);
        chk("dl1", 32'(flags.brake_release_out), 32'h1);
        run(SSO_MODE_SPD, 1'b1, 1000, 1070);
        chk("sa", 32'(flags.speed_attained), 32'h1);
        run(SSO_MODE_SPD, 1'b1, 1000, 929);
        chk("sa", 32'(flags.speed_attained), 32'h0);
        run(SSO_MODE_SPD, 1'b1, 20, 500);
        chk("sa", 32'(flags.speed_attained), 32'h1);
        run(SSO_MODE_SPD, 1'b0, 20, 500);
        chk("sa", 32'(flags.speed_attained), 32'h0);
        run(SSO_MODE_TRQ, 1'b1, 20, 300);
        chk("sa", 32'(flags.speed_attained), 32'h0);
        chk("vl", 32'(flags.speed_limit_active), 32'h1);
        run(SSO_MODE_TRQ, 1'b1, 20, 299);
        chk("vl", 32'(flags.speed_limit_active), 32'h0);
        run(SSO_MODE_TRQ, 1'b0, 20, 300);
        chk("vl", 32'(flags.speed_limit_active), 32'h0);
        run(SSO_MODE_SPD, 1'b1, 20, 300);
        chk("vl", 32'(flags.speed_limit_active), 32'h0);
        droop_pulses <= 32'sd150;
        run(SSO_MODE_POS, 1'b1, 1000, 1000);
        chk("sa", 32'(flags.speed_attained), 32'h0);
        chk("vl", 32'(flags.speed_limit_active), 32'h0);
        chk("inp", 32'(flags.position_settled), 32'h0);
        bus(1'b1, OFF_SETTLE, 32'h96);
        tick(3);
        chk("inp", 32'(flags.position_settled), 32'h1);
        run(SSO_MODE_SPD, 1'b1, 1000, 1000);
        chk("inp", 32'(flags.position_settled), 32'h0);
        for (int i = 0; i < 7; i++) begin
            run(SSO_MODE_SPD, 1'b1, 0, nz_v[i]);
            chk("zsp", 32'(flags.near_zero_speed), 32'(nz_e[i]));
        end
        bus(1'b1, OFF_ZSPD, 32'h64);
        run(SSO_MODE_SPD, 1'b1, 0, 100);
        chk("zsp", 32'(flags.near_zero_speed), 32'h1);
        wrap_up();
    end
endmodule : sso_status_outputs_tb
